// File: design/hsps_pkg.sv
package hsps_pkg;

	// Clock rate in kHz, used to turn times into cycle counts.
	localparam int unsigned CLK_KHZ = 40000;

	// Card-detect qualification delay in microseconds.
	localparam int unsigned CARD_DETECT_DELAY_US = 100;
	// Cycles in the card-detect delay, rounded up.
	localparam int unsigned CARD_DETECT_DELAY_CYC = (CARD_DETECT_DELAY_US * CLK_KHZ + 999) / 1000;

	// Cool-down period before a retry, in microseconds.
	localparam int unsigned COOLDOWN_PERIOD_US = 1000;
	// Cycles in the cool-down period, rounded up.
	localparam int unsigned COOLDOWN_PERIOD_CYC = (COOLDOWN_PERIOD_US * CLK_KHZ + 999) / 1000;

	// Converter-enable delay step in microseconds; slot k waits k+1 steps.
	localparam int unsigned CONV_ENABLE_DELAY_US = 10;
	// Cycles per converter-enable delay step, rounded up.
	localparam int unsigned CONV_ENABLE_DELAY_CYC = (CONV_ENABLE_DELAY_US * CLK_KHZ + 999) / 1000;

	// Width of the delay counters.
	localparam int unsigned CNT_W = 24;
	// Number of converter-enable outputs.
	localparam int unsigned NUM_CONV = 4;

	// Sequencer states, one-hot.
	typedef enum logic [5:0] {
		ST_IDLE     = 6'h01,
		ST_QUALIFY  = 6'h02,
		ST_RAMP     = 6'h04,
		ST_RUN      = 6'h08,
		ST_LATCHED  = 6'h10,
		ST_COOLDOWN = 6'h20
	} hsps_state_t;

endpackage : hsps_pkg

// File: design/hsps_seq_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries the start request and the delay setting to one converter-enable slot.
interface hsps_seq_if;
	logic                     start;  // High while the converters may be enabled.
	logic [hsps_pkg::CNT_W-1:0] delay; // Cycles from start to assertion.
	logic                     done;   // High once the slot has asserted.

	modport ctl (output start, output delay, input done);
	modport slot (input start, input delay, output done);
endinterface : hsps_seq_if

`default_nettype wire

// File: design/hsps_conv_slot.sv
`timescale 1ns/10ps
`default_nettype none

// One converter-enable slot: counts its own delay once started, clears at once when start drops.
module hsps_conv_slot (
	input  wire logic MCLK,
	input  wire logic RESET,
	hsps_seq_if.slot  sq
);
	// All state of the slot.
	typedef struct packed {
		logic [hsps_pkg::CNT_W-1:0] cnt;  // Cycles elapsed since start.
		logic                       done; // Slot asserted.
	} hsps_slot_t;

	hsps_slot_t s;      // Registered state.
	hsps_slot_t next_s; // Next state.

	// Count up while started; assert on reaching the delay.
	always_comb begin
		next_s = s;
		if (!sq.start) begin
			next_s = '0; // [R20]
		end else if (!s.done) begin
			if (s.cnt >= sq.delay) begin
				next_s.done = 1'b1; // [R18]
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end
	end

	// Register the state.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sq.done = s.done;
endmodule : hsps_conv_slot

`default_nettype wire

// File: design/hsps_sequencer.sv
// Notes on behaviour
// [R1] Watch both feeds, pick one in range.
// [R2] Drive gate of the chosen feed.
// [R3] Move to most negative valid feed.
// [R4] Main gate off until qualified after power-up.
// [R5] Undervoltage and overvoltage both in range.
// [R6] Both card-seated inputs must be high.
// [R7] Conditions held for card-detect delay, then gate.
// [R8] Converters on when drain low, gate good.
// [R9] Run only while all conditions stay normal.
// [R10] Any fault turns switches and converters off. Here only the main gate and converters drop; the feed gates stay on unless master enable is low.
// [R11] Faults: supply range, drain, card detect.
// [R12] Master enable low shuts gates off.
// [R13] Any secondary feedback low shuts down.
// [R14] Overcurrent shuts down.
// [R15] After shutdown latch off or retry.
// [R16] Reset clears latch, disables all outputs.
// [R17] Active-low fault output reflects fault state.
// [R18] Each converter: polarity, slot, own delay.
// [R19] Lapse during delay restarts the count.
// [R20] Shutdown drops converter enables with gates.
`timescale 1ns/10ps
`default_nettype none

module hsps_sequencer (
	input  wire logic                      MCLK,
	input  wire logic                      RESET,
	input  wire logic                      FEED_A_VALID,
	input  wire logic                      FEED_B_VALID,
	input  wire logic                      FEED_B_MORE_NEG,
	input  wire logic                      UNDERVOLTAGE_MONITOR_OK,
	input  wire logic                      OVERVOLTAGE_MONITOR_OK,
	input  wire logic                      CARD_SEATED_IN0,
	input  wire logic                      CARD_SEATED_IN1,
	input  wire logic                      DRAIN_SENSE_LOW,
	input  wire logic                      GATE_GOOD_THRESHOLD,
	input  wire logic                      MASTER_ENABLE_IN,
	input  wire logic [3:0]                SECONDARY_FEEDBACK_IN,
	input  wire logic                      OVERCURRENT,
	input  wire logic                      LATCH_MODE,
	input  wire logic [3:0]                CONV_POLARITY,
	input  wire logic [7:0]                CONV_POSITION,
	output logic                           FEED_A_GATE_OUT,
	output logic                           FEED_B_GATE_OUT,
	output logic                           MAIN_SWITCH_GATE_OUT,
	output logic                           CONV_ENABLE_A,
	output logic                           CONV_ENABLE_B,
	output logic                           CONV_ENABLE_C,
	output logic                           CONV_ENABLE_D,
	output logic                           FAULT_N,
	output logic [5:0]                     STATUS
);
	// All state of the sequencer.
	typedef struct packed {
		hsps_pkg::hsps_state_t       st;      // Sequencer state.
		logic [hsps_pkg::CNT_W-1:0]  cnt;     // Qualify or cool-down counter.
		logic                        sel_b;   // Feed B is the chosen source.
		logic                        feed_on; // A feed is chosen.
		logic                        fault;   // Fault seen since last start.
		logic [5:0]                  cause;   // Sticky fault causes.
		logic [3:0]                  conv;    // Converter enables, active high.
	} hsps_top_t;

	hsps_top_t s;      // Registered state.
	hsps_top_t next_s; // Next state.

	hsps_seq_if sq [hsps_pkg::NUM_CONV] (); // One carrier per converter slot.
	logic [3:0] slot_done;                  // Slot has timed out, by position.

	// Combinational views of the pins, recomputed every cycle.
	logic       on_ok;     // All turn-on conditions hold.
	logic [5:0] fault_now; // Fault and shutdown causes this cycle, raw.
	logic [5:0] fault_eff; // Causes that count as faults in the present state.
	logic       any_fault; // Any effective cause present.

	// Turn-on conditions and shutdown causes.
	// The bit order of the cause vector is the bit order of the status outputs.
	always_comb begin
		on_ok = UNDERVOLTAGE_MONITOR_OK && OVERVOLTAGE_MONITOR_OK // [R5]
			&& CARD_SEATED_IN0 && CARD_SEATED_IN1 // [R6]
			&& MASTER_ENABLE_IN && s.feed_on;
		fault_now[0] = !(UNDERVOLTAGE_MONITOR_OK && OVERVOLTAGE_MONITOR_OK); // [R11]
		fault_now[1] = !DRAIN_SENSE_LOW; // [R11]
		fault_now[2] = !(CARD_SEATED_IN0 && CARD_SEATED_IN1); // [R11]
		fault_now[3] = !MASTER_ENABLE_IN; // [R12]
		fault_now[4] = !(&SECONDARY_FEEDBACK_IN); // [R13]
		fault_now[5] = OVERCURRENT; // [R14]
		// Drain sense stays high while the main gate ramps, so a high drain only counts once a converter runs.
		fault_eff    = fault_now;
		fault_eff[1] = fault_now[1] && (|s.conv); // [R11]
		any_fault    = |fault_eff;
	end

	// Slot k counts delay k+1 steps; each output picks one of the four slots.
	// All slots start together, so the order comes only from the delays.
	genvar k;
	generate
		for (k = 0; k < hsps_pkg::NUM_CONV; k++) begin : g_slot
			assign sq[k].start = s.st[3] && DRAIN_SENSE_LOW && GATE_GOOD_THRESHOLD; // [R8]
			assign sq[k].delay = hsps_pkg::CNT_W'((k + 1) * hsps_pkg::CONV_ENABLE_DELAY_CYC); // [R18]
			assign slot_done[k] = sq[k].done;
			hsps_conv_slot u_slot (
				.MCLK  (MCLK),
				.RESET (RESET),
				.sq    (sq[k])
			);
		end
	endgenerate

	// Next-state logic: feed arbitration, qualification, run and recovery.
	always_comb begin
		next_s = s;
		// Feed choice runs in every state.
		if (FEED_A_VALID && FEED_B_VALID) begin
			// Both in range: follow the more negative feed.
			next_s.sel_b = FEED_B_MORE_NEG; // [R3]
		end else begin
			// Otherwise take whichever one is in range.
			next_s.sel_b = FEED_B_VALID; // [R1]
		end
		next_s.feed_on = FEED_A_VALID || FEED_B_VALID; // [R1]
		// Each output follows the slot named by its two position bits.
		for (int i = 0; i < 4; i++) begin
			next_s.conv[i] = slot_done[CONV_POSITION[2*i +: 2]]; // [R18]
		end
		// Sequencer state walk.
		case (s.st)
			hsps_pkg::ST_IDLE: begin
				// Main gate stays off here until every turn-on condition holds.
				next_s.cnt = '0;
				if (on_ok) begin
					next_s.st = hsps_pkg::ST_QUALIFY; // [R4]
				end
			end
			hsps_pkg::ST_QUALIFY: begin
				if (!on_ok) begin
					// A lapse sends the count back to zero.
					next_s.cnt = '0; // [R19]
					next_s.st  = hsps_pkg::ST_IDLE;
				end else if (s.cnt >= hsps_pkg::CNT_W'(hsps_pkg::CARD_DETECT_DELAY_CYC - 1)) begin
					// Full delay seen: start a fresh run with clean fault flags.
					next_s.st    = hsps_pkg::ST_RUN; // [R7]
					next_s.fault = 1'b0;
					next_s.cause = '0;
				end else begin
					// Still counting the qualification delay.
					next_s.cnt = s.cnt + 1'b1;
				end
			end
			hsps_pkg::ST_RUN: begin
				// Leave the run state on any effective cause, or when both feeds are lost.
				if (any_fault || !s.feed_on) begin
					// Only the causes that counted are reported, so a ramping drain is not blamed.
					next_s.cause = fault_eff; // [R9]
					next_s.fault = 1'b1;
					next_s.conv  = '0; // [R20]
					next_s.cnt   = '0;
					next_s.st    = LATCH_MODE ? hsps_pkg::ST_LATCHED : hsps_pkg::ST_COOLDOWN; // [R15]
				end
			end
			hsps_pkg::ST_LATCHED: begin
				// Only reset leaves this state.
				next_s.conv = '0; // [R10]
			end
			hsps_pkg::ST_COOLDOWN: begin
				// Count out the cool-down, then try a fresh start.
				next_s.conv = '0; // [R10]
				if (s.cnt >= hsps_pkg::CNT_W'(hsps_pkg::COOLDOWN_PERIOD_CYC - 1)) begin
					next_s.st  = hsps_pkg::ST_IDLE; // [R15]
					next_s.cnt = '0;
				end else begin
					next_s.cnt = s.cnt + 1'b1;
				end
			end
			default: begin
				// Unused codes fall back to a safe idle.
				next_s.st = hsps_pkg::ST_IDLE;
			end
		endcase
		// Converters may only run together with the main gate.
		if (next_s.st != hsps_pkg::ST_RUN) begin
			next_s.conv = '0; // [R20]
		end
	end

	// Register the state; reset clears latched faults.
	// This register is the only place where a latched fault is cleared.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			s    <= '0; // [R16]
			s.st <= hsps_pkg::ST_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// Output flip-flops.
	// Reset drives every converter enable to the inactive level of its polarity.
	// A low master enable turns the feed gates off as well as the main gate.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			FEED_A_GATE_OUT      <= 1'b0; // [R16]
			FEED_B_GATE_OUT      <= 1'b0;
			MAIN_SWITCH_GATE_OUT <= 1'b0;
			CONV_ENABLE_A        <= CONV_POLARITY[0] ? 1'b0 : 1'b1;
			CONV_ENABLE_B        <= CONV_POLARITY[1] ? 1'b0 : 1'b1;
			CONV_ENABLE_C        <= CONV_POLARITY[2] ? 1'b0 : 1'b1;
			CONV_ENABLE_D        <= CONV_POLARITY[3] ? 1'b0 : 1'b1;
			FAULT_N              <= 1'b1;
			STATUS               <= '0;
		end else begin
			FEED_A_GATE_OUT      <= next_s.feed_on && !next_s.sel_b && MASTER_ENABLE_IN; // [R2] [R12]
			FEED_B_GATE_OUT      <= next_s.feed_on && next_s.sel_b && MASTER_ENABLE_IN; // [R2] [R12]
			MAIN_SWITCH_GATE_OUT <= (next_s.st == hsps_pkg::ST_RUN); // [R7]
			CONV_ENABLE_A        <= next_s.conv[0] ~^ CONV_POLARITY[0]; // [R18]
			CONV_ENABLE_B        <= next_s.conv[1] ~^ CONV_POLARITY[1];
			CONV_ENABLE_C        <= next_s.conv[2] ~^ CONV_POLARITY[2];
			CONV_ENABLE_D        <= next_s.conv[3] ~^ CONV_POLARITY[3];
			FAULT_N              <= !next_s.fault; // [R17]
			STATUS               <= next_s.cause; // [R17]
		end
	end
endmodule : hsps_sequencer

`default_nettype wire

// File: tb/hsps_sequencer_checker.sv
`timescale 1ns/10ps
`default_nettype none
// Checks gate, converter and fault timing at the pins.
module hsps_sequencer_checker (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic FEED_A_VALID,
	input wire logic FEED_B_VALID,
	input wire logic FEED_B_MORE_NEG,
	input wire logic UNDERVOLTAGE_MONITOR_OK,
	input wire logic OVERVOLTAGE_MONITOR_OK,
	input wire logic CARD_SEATED_IN0,
	input wire logic CARD_SEATED_IN1,
	input wire logic DRAIN_SENSE_LOW,
	input wire logic GATE_GOOD_THRESHOLD,
	input wire logic MASTER_ENABLE_IN,
	input wire logic OVERCURRENT,
	input wire logic LATCH_MODE,
	input wire logic [3:0] CONV_POLARITY,
	input wire logic FEED_A_GATE_OUT,
	input wire logic FEED_B_GATE_OUT,
	input wire logic MAIN_SWITCH_GATE_OUT,
	input wire logic CONV_ENABLE_A,
	input wire logic CONV_ENABLE_B,
	input wire logic CONV_ENABLE_C,
	input wire logic CONV_ENABLE_D,
	input wire logic FAULT_N
);
	wire logic gate = MAIN_SWITCH_GATE_OUT; // Main gate.
	// Converter enables as active bits.
	wire logic [3:0] act = {CONV_ENABLE_D, CONV_ENABLE_C, CONV_ENABLE_B, CONV_ENABLE_A} ~^ CONV_POLARITY;
	wire logic ok = UNDERVOLTAGE_MONITOR_OK && OVERVOLTAGE_MONITOR_OK && CARD_SEATED_IN0 && CARD_SEATED_IN1;
	logic [12:0] held; // Cycles that ok has held.
	// Counts qualified cycles, saturating.
	always_ff @(posedge MCLK) begin
		if (RESET || !ok) held <= 13'h0000;
		else if (held != 13'h1fff) held <= held + 13'h0001;
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	chk_gate_qualify: assert property ($rose(gate) |-> held >= hsps_pkg::CARD_DETECT_DELAY_CYC)
		else $error("gate rose early");
	chk_enable_off: assert property (!MASTER_ENABLE_IN |-> ##[1:2] !gate)
		else $error("gate on without enable");
	chk_overcurrent_off: assert property (OVERCURRENT |-> ##[1:2] !gate)
		else $error("gate on after overcurrent");
	chk_conv_cause: assert property ($rose(|act) |-> gate && $past(DRAIN_SENSE_LOW && GATE_GOOD_THRESHOLD))
		else $error("converter on too soon");
	chk_conv_drop: assert property ($fell(gate) |-> act == 4'h0)
		else $error("converter left on");
	chk_fault_flag: assert property ($fell(gate) |-> !FAULT_N)
		else $error("shutdown without flag");
	chk_latch_hold: assert property (LATCH_MODE && !FAULT_N |=> !gate)
		else $error("gate on while latched");
	// The sampled reset keeps the release edge out, where the outputs still hold their reset values.
	chk_feed_pick: assert property (!RESET && FAULT_N && MASTER_ENABLE_IN && FEED_A_VALID && FEED_B_VALID
		|=> FEED_B_GATE_OUT == $past(FEED_B_MORE_NEG)) else $error("wrong feed");
	chk_enable_feeds: assert property (!MASTER_ENABLE_IN |=> !FEED_A_GATE_OUT && !FEED_B_GATE_OUT)
		else $error("feed gate on without enable");
	cover property ($rose(gate));
	cover property (act == 4'hf);
	cover property ($fell(gate) && !LATCH_MODE);
endmodule : hsps_sequencer_checker
bind hsps_sequencer hsps_sequencer_checker hsps_sequencer_checker_inst (.*);
`default_nettype wire

// File: tb/hsps_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
// External main switch: drain falls, then the gate charges.
module hsps_switch_model #(parameter int RAMP = 20) (
	input  wire logic mclk,
	input  wire logic gate_on,
	output logic      drain_low,
	output logic      gate_good
);
	logic [7:0] cnt; // Cycles since drive began.
	// Restarts at once when drive is released.
	always_ff @(posedge mclk) begin
		if (!gate_on) cnt <= 8'h00;
		else if (cnt != 8'hff) cnt <= cnt + 8'h01;
	end
	assign drain_low = cnt >= 8'(RAMP);
	assign gate_good = cnt >= 8'(RAMP + 4);
endmodule : hsps_switch_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
// Runs start-up, converter order and both fault modes.
module tb;
	logic MCLK, RESET, FEED_A_VALID, FEED_B_VALID, FEED_B_MORE_NEG, OVERCURRENT, LATCH_MODE;
	logic UNDERVOLTAGE_MONITOR_OK, OVERVOLTAGE_MONITOR_OK, CARD_SEATED_IN0, CARD_SEATED_IN1;
	logic DRAIN_SENSE_LOW, GATE_GOOD_THRESHOLD, MASTER_ENABLE_IN, FAULT_N;
	logic FEED_A_GATE_OUT, FEED_B_GATE_OUT, MAIN_SWITCH_GATE_OUT;
	logic CONV_ENABLE_A, CONV_ENABLE_B, CONV_ENABLE_C, CONV_ENABLE_D;
	logic [3:0] SECONDARY_FEEDBACK_IN, CONV_POLARITY;
	logic [7:0] CONV_POSITION;
	logic [5:0] STATUS;
	int err_total, total_checks, n;
	wire logic gate = MAIN_SWITCH_GATE_OUT; // Main gate.
	// Converter enables as active bits.
	wire logic [3:0] act = {CONV_ENABLE_D, CONV_ENABLE_C, CONV_ENABLE_B, CONV_ENABLE_A} ~^ CONV_POLARITY;
	hsps_sequencer hsps_sequencer_inst (.*);
	hsps_switch_model hsps_switch_model_inst (.mclk(MCLK), .gate_on(gate), .drain_low(DRAIN_SENSE_LOW),
		.gate_good(GATE_GOOD_THRESHOLD));
	// Counts a comparison and reports a mismatch.
	task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Lets k edges pass, then settles to the falling edge.
	task automatic look(input int k);
		repeat (k) @(posedge MCLK);
		@(negedge MCLK);
	endtask : look
	// Waits up to k cycles for the gate to reach v.
	task automatic wait_gate(input logic v, input int k);
		for (n = 0; n < k && gate !== v; n++) @(negedge MCLK);
	endtask : wait_gate
	// Prints the verdict and ends the run.
	task automatic results;
		if (err_total == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	// Resets; all off, and feed B is chosen as more negative.
	task automatic t_reset;
		@(posedge MCLK);
		RESET <= 1'b1;
		repeat (2) @(posedge MCLK);
		RESET <= 1'b0;
		look(2);
		check("idle", {gate, act, FAULT_N}, 6'h01);
		check("status", STATUS, 6'h00);
		check("feeds", {FEED_A_GATE_OUT, FEED_B_GATE_OUT}, 6'h01);
	endtask : t_reset
	// Feed choice follows validity, then the more negative feed; ends with B chosen.
	task automatic t_feeds;
		@(posedge MCLK);
		FEED_B_MORE_NEG <= 1'b0;
		look(1);
		check("feed a neg", {FEED_A_GATE_OUT, FEED_B_GATE_OUT}, 6'h02);
		@(posedge MCLK);
		FEED_A_VALID <= 1'b0;
		look(1);
		check("feed b only", {FEED_A_GATE_OUT, FEED_B_GATE_OUT}, 6'h01);
		@(posedge MCLK);
		{FEED_A_VALID, FEED_B_VALID} <= 2'b10;
		look(1);
		check("feed a only", {FEED_A_GATE_OUT, FEED_B_GATE_OUT}, 6'h02);
		@(posedge MCLK);
		FEED_A_VALID <= 1'b0;
		look(1);
		check("no feed", {FEED_A_GATE_OUT, FEED_B_GATE_OUT}, 6'h00);
		@(posedge MCLK);
		{FEED_A_VALID, FEED_B_VALID, FEED_B_MORE_NEG} <= 3'b111;
		look(1);
		check("feed b neg", {FEED_A_GATE_OUT, FEED_B_GATE_OUT}, 6'h01);
	endtask : t_feeds
	// Qualifies, breaks seating part-way, then needs the full delay.
	task automatic t_qualify;
		@(posedge MCLK);
		UNDERVOLTAGE_MONITOR_OK <= 1'b1;
		OVERVOLTAGE_MONITOR_OK <= 1'b1;
		CARD_SEATED_IN0 <= 1'b1;
		CARD_SEATED_IN1 <= 1'b1;
		look(3000);
		check("early", gate, 1'b0);
		@(posedge MCLK);
		CARD_SEATED_IN1 <= 1'b0;
		@(posedge MCLK);
		CARD_SEATED_IN1 <= 1'b1;
		look(hsps_pkg::CARD_DETECT_DELAY_CYC - 10);
		check("relapse", gate, 1'b0);
		wait_gate(1'b1, 30);
		check("qualified", gate, 1'b1);
	endtask : t_qualify
	// A..D sit in slots 3..0, so D leads.
	task automatic t_conv;
		for (n = 0; n < 2000 && act === 4'h0; n++) @(negedge MCLK);
		check("first conv", act, 6'h08);
		for (n = 0; n < 2000 && act !== 4'hf; n++) @(negedge MCLK);
		check("all conv", act, 6'h0f);
	endtask : t_conv
	// Overcurrent in latch mode stays down until reset.
	task automatic t_latch;
		@(posedge MCLK);
		OVERCURRENT <= 1'b1;
		@(posedge MCLK);
		OVERCURRENT <= 1'b0;
		look(1);
		check("trip", {gate, act, FAULT_N}, 6'h00);
		check("cause", STATUS, 6'h20);
		look(3000);
		check("latched", gate, 1'b0);
	endtask : t_latch
	// Enable drop in retry mode: off for the cool-down, then restart.
	task automatic t_retry;
		@(posedge MCLK);
		LATCH_MODE <= 1'b0;
		wait_gate(1'b1, 4100);
		@(posedge MCLK);
		MASTER_ENABLE_IN <= 1'b0;
		@(posedge MCLK);
		MASTER_ENABLE_IN <= 1'b1;
		@(negedge MCLK);
		check("feeds off", {FEED_A_GATE_OUT, FEED_B_GATE_OUT}, 6'h00);
		look(hsps_pkg::COOLDOWN_PERIOD_CYC - 50);
		check("cooling", gate, 1'b0);
		check("cause", STATUS, 6'h08);
		wait_gate(1'b1, 4200);
		check("restart", gate, 1'b1);
	endtask : t_retry
	// Secondary feedback low while the gate ramps; a high drain then is not a cause.
	task automatic t_feedback;
		wait_gate(1'b1, 4100);
		@(posedge MCLK);
		SECONDARY_FEEDBACK_IN <= 4'hb;
		@(posedge MCLK);
		SECONDARY_FEEDBACK_IN <= 4'hf;
		look(1);
		check("feedback trip", {gate, act, FAULT_N}, 6'h00);
		check("feedback cause", STATUS, 6'h10);
	endtask : t_feedback
	// Sets every input at time zero, then runs the scenarios.
	initial begin
		err_total = 0;
		total_checks = 0;
		RESET = 1'b1;
		{FEED_A_VALID, FEED_B_VALID, FEED_B_MORE_NEG, MASTER_ENABLE_IN, LATCH_MODE} = 5'h1f;
		{UNDERVOLTAGE_MONITOR_OK, OVERVOLTAGE_MONITOR_OK, CARD_SEATED_IN0, CARD_SEATED_IN1, OVERCURRENT} = 5'h00;
		SECONDARY_FEEDBACK_IN = 4'hf;
		CONV_POLARITY = 4'h5;
		CONV_POSITION = 8'h1b;
		t_reset;
		t_feeds;
		t_qualify;
		t_conv;
		t_latch;
		t_reset;
		t_feedback;
		t_reset;
		t_retry;
		results;
	end
	// Clock of 25 ns.
	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	// Cuts a hang short well past the expected run.
	initial begin
		repeat (80000) @(posedge MCLK);
		err_total++;
		results;
	end
endmodule : tb
`default_nettype wire
